// >>> logic/pmra_regs.svh
`ifndef PMRA_REGS_SVH
`define PMRA_REGS_SVH

// Command codes driven on the command/byte-enable lines
`define PMRA_CMD_IACK      4'h0
`define PMRA_CMD_IO_RD     4'h2
`define PMRA_CMD_IO_WR     4'h3
`define PMRA_CMD_MEM_RD    4'h6
`define PMRA_CMD_MEM_WR    4'h7
`define PMRA_CMD_CFG_RD    4'hA
`define PMRA_CMD_CFG_WR    4'hB
`define PMRA_CMD_MEM_RDM   4'hC
`define PMRA_CMD_MEM_RDL   4'hE
// Codes this master must never present
`define PMRA_CMD_SPECIAL   4'h1
`define PMRA_CMD_DAC       4'hD
`define PMRA_CMD_MWI       4'hF
// Write-invalidate enable is hard-wired to zero
`define PMRA_WRITE_INVALIDATE_ENABLE_VALUE  1'b0
// Field widths
`define PMRA_ADDR_W        32
`define PMRA_SIZE_W        5
// Idle value of byte-enable lines between phases
`define PMRA_CBE_IDLE      4'hF

`endif

// >>> logic/pmra_pkg.sv
package pmra_pkg;

    // Source of a transfer request
    typedef enum logic [1:0] {
        PMRA_SRC_PROC = 2'h1,
        PMRA_SRC_ALT = 2'h2
    } pmra_src_type;

    // Kind of transfer the source asks for
    typedef enum logic [3:0] {
        PMRA_OP_IO_RD = 4'h0,
        PMRA_OP_IO_WR = 4'h1,
        PMRA_OP_MEM_RD = 4'h2,
        PMRA_OP_MEM_WR = 4'h3,
        PMRA_OP_MEM_RDM = 4'h4,
        PMRA_OP_MEM_RDL = 4'h5,
        PMRA_OP_IACK = 4'h6,
        PMRA_OP_CFG_RD = 4'h7,
        PMRA_OP_CFG_WR = 4'h8
    } pmra_op_type;

    // Request bundle from the processor bus or alternate port
    typedef struct packed {
        logic [31:0] addr;
        pmra_op_type op;
        pmra_src_type src;
        logic translation_enable;
        logic [4:0] block_size;
        logic [31:0] xlat_offset;
    } pmra_req_type;

    // Address phase bundle presented on the bus
    typedef struct packed {
        logic [31:0] addr;
        logic [3:0] cmd;
    } pmra_addr_type;

endpackage

// >>> logic/pmra_master.sv
`timescale 1ns/1ps
`include "pmra_regs.svh"

// Functional notes
// [RL1] Each processor bus or alternate port transfer raises a bus request.
// [RL2] With the on-chip arbiter on, the request never reaches the pin.
// [RL3] Arbiter off: the pin carries the request and outside logic grants it.
// [RL4] The on-chip arbiter parks its grant here while no other master asks.
// [RL5] Once requested and granted, the master asserts frame to start.
// [RL6] The address phase drives the command code on the four command lines.
// [RL7] I/O read is code 0010 and I/O write is code 0011.
// [RL8] Memory read 0110, write 0111, read multiple 1100, read line 1110.
// [RL9] Interrupt acknowledge 0000, configuration read 1010, write 1011.
// [RL10] Special cycle, dual address and reserved codes are never issued.
// [RL11] Write-and-invalidate is never issued and its enable bit reads zero.
// [RL12] Translation applies when the source image enables it.
// [RL13] Translation uses the source address, the block size and the offset.
// [RL14] Without translation the bus address equals the source address.
// [RL15] Translated: high bits from the offset, bits inside the block from source.
// [RL16] No transaction starts unless bus master enable is set.
// [RL17] The device is never master and target on the bus at the same time.
module pmra_master (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic req_valid_i,
    input wire pmra_pkg::pmra_req_type req_i,
    input wire logic bus_master_enable_i,
    input wire logic arb_internal_i,
    input wire logic other_req_i,
    input wire logic target_busy_i,
    input wire logic pci_grant_n_i,
    input wire logic addr_done_i,
    output logic req_ready_o,
    output logic pci_req_n_o,
    output logic int_req_o,
    output logic int_grant_o,
    output logic pci_frame_n_o,
    output logic pci_frame_oe_o,
    output logic [3:0] pci_cmd_byte_en_n_o,
    output logic pci_cmd_oe_o,
    output logic [31:0] pci_ad_o,
    output logic pci_ad_oe_o,
    output logic master_active_o,
    output logic write_invalidate_enable_o
);
    import pmra_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_REQ = 3'h2,
        ST_ADDR = 3'h4
    } pmra_state_type;

    pmra_state_type state;
    pmra_state_type next_state;
    pmra_req_type held;
    pmra_addr_type next_phase;

    // Address mask: ones below the block size keep the source bits
    wire [31:0] low_mask;
    wire [31:0] xlat_addr;
    wire [31:0] bus_addr;
    wire [3:0] cmd_code;
    wire grant_seen;
    wire int_grant;
    wire may_start;
    wire req_granted;

    assign low_mask = (32'h1 << held.block_size) - 32'h1;
    assign xlat_addr = (held.xlat_offset & ~low_mask)
        | (held.addr & low_mask); // see [RL13] [RL15]
    assign bus_addr = held.translation_enable ? xlat_addr
        : held.addr; // see [RL12] [RL14]

    // Command decode; unknown ops fall back to a safe memory read so
    // no forbidden code can ever leave the block
    assign cmd_code =
        (held.op == PMRA_OP_IO_RD)   ? `PMRA_CMD_IO_RD :    // see [RL7]
        (held.op == PMRA_OP_IO_WR)   ? `PMRA_CMD_IO_WR :
        (held.op == PMRA_OP_MEM_WR)  ? `PMRA_CMD_MEM_WR :   // see [RL8]
        (held.op == PMRA_OP_MEM_RDM) ? `PMRA_CMD_MEM_RDM :
        (held.op == PMRA_OP_MEM_RDL) ? `PMRA_CMD_MEM_RDL :
        (held.op == PMRA_OP_IACK)    ? `PMRA_CMD_IACK :     // see [RL9]
        (held.op == PMRA_OP_CFG_RD)  ? `PMRA_CMD_CFG_RD :
        (held.op == PMRA_OP_CFG_WR)  ? `PMRA_CMD_CFG_WR :
        `PMRA_CMD_MEM_RD; // see [RL10] [RL11]

    assign next_phase.addr = bus_addr;
    assign next_phase.cmd = cmd_code;

    // Internal arbiter grants us when we ask, or parks here when idle
    assign int_grant = arb_internal_i
        & ((state == ST_REQ) | ~other_req_i);               // see [RL4]
    assign grant_seen = arb_internal_i ? int_grant
        : ~pci_grant_n_i;                                   // see [RL3]
    // Never start while acting as target on this bus
    assign may_start = bus_master_enable_i
        & ~target_busy_i; // see [RL16] [RL17]
    // Request state meeting a grant: the edge before frame falls
    assign req_granted = (state == ST_REQ) & grant_seen;

    // Sequencer: idle, arbitrate, then hold the address phase
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (req_valid_i && may_start) begin
                    next_state = ST_REQ;                    // see [RL1]
                end
            end
            ST_REQ: begin
                if (!may_start) begin
                    next_state = ST_IDLE;
                end else if (grant_seen) begin
                    next_state = ST_ADDR;                   // see [RL5]
                end
            end
            ST_ADDR: begin
                if (addr_done_i) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Capture the request as it is accepted
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            held <= '0;
        end else if (state == ST_IDLE && req_valid_i && may_start) begin
            held <= req_i;
        end
    end

    // Registered pin drivers; request routed by arbiter mode
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            pci_req_n_o <= 1'b1;
            int_req_o <= 1'b0;
            int_grant_o <= 1'b0;
            pci_frame_n_o <= 1'b1;
            pci_frame_oe_o <= 1'b0;
            pci_cmd_byte_en_n_o <= `PMRA_CBE_IDLE;
            pci_cmd_oe_o <= 1'b0;
            pci_ad_o <= 32'h0;
            pci_ad_oe_o <= 1'b0;
            master_active_o <= 1'b0;
            req_ready_o <= 1'b0;
        end else begin
            pci_req_n_o <= ~((next_state == ST_REQ)
                & ~arb_internal_i);                         // see [RL3]
            int_req_o <= (next_state == ST_REQ)
                & arb_internal_i;                           // see [RL2]
            int_grant_o <= int_grant;                       // see [RL4]
            pci_frame_n_o <= ~(next_state == ST_ADDR);      // see [RL5]
            pci_frame_oe_o <= (next_state == ST_ADDR);
            pci_cmd_byte_en_n_o <= (next_state == ST_ADDR)
                ? next_phase.cmd : `PMRA_CBE_IDLE;          // see [RL6]
            pci_cmd_oe_o <= (next_state == ST_ADDR);
            pci_ad_o <= (next_state == ST_ADDR) ? next_phase.addr : 32'h0;
            pci_ad_oe_o <= (next_state == ST_ADDR);
            master_active_o <= (next_state != ST_IDLE);     // see [RL17]
            req_ready_o <= (next_state == ST_IDLE);
        end
    end

    // Hard-wired zero, never writable
    always_ff @(posedge clk_sys_i) begin
        write_invalidate_enable_o <= `PMRA_WRITE_INVALIDATE_ENABLE_VALUE;    // see [RL11]
    end

    chk_no_bad_cmd: assert property ( // see [RL10]
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        !pci_cmd_oe_o || (pci_cmd_byte_en_n_o != `PMRA_CMD_SPECIAL
            && pci_cmd_byte_en_n_o != `PMRA_CMD_DAC
            && pci_cmd_byte_en_n_o != 4'h4
            && pci_cmd_byte_en_n_o != 4'h5
            && pci_cmd_byte_en_n_o != 4'h8
            && pci_cmd_byte_en_n_o != 4'h9))
        else $error("forbidden command code driven");
    chk_no_mwi_cmd: assert property ( // see [RL11]
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        !pci_cmd_oe_o || pci_cmd_byte_en_n_o != `PMRA_CMD_MWI)
        else $error("write and invalidate issued");
    chk_frame_needs_bm: assert property ( // see [RL16]
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        $fell(pci_frame_n_o) |-> $past(bus_master_enable_i))
        else $error("frame started without bus master enable");
    chk_frame_after_gnt: assert property ( // see [RL5]
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        $fell(pci_frame_n_o) |-> $past(req_granted))
        else $error("frame without prior grant");
    chk_pin_req_ext: assert property ( // see [RL2]
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        $past(arb_internal_i) |-> pci_req_n_o)
        else $error("pin request driven with internal arbiter");
    chk_ext_req_shown: assert property ( // see [RL3]
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (state == ST_REQ && !arb_internal_i && may_start && pci_grant_n_i)
        |=> !pci_req_n_o)
        else $error("external request not shown");
    chk_req_raised: assert property ( // see [RL1]
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (state == ST_IDLE && req_valid_i && may_start) |=>
        (state == ST_REQ) ##0 (int_req_o || !pci_req_n_o))
        else $error("request not raised");
    chk_park_idle: assert property ( // see [RL4]
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (arb_internal_i && !other_req_i) |=> int_grant_o)
        else $error("bus not parked");
    chk_plain_addr: assert property ( // see [RL14]
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        ($fell(pci_frame_n_o) && !held.translation_enable)
        |-> pci_ad_o == held.addr)
        else $error("untranslated address differs");
    chk_xlat_addr: assert property ( // see [RL15]
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        ($fell(pci_frame_n_o) && held.translation_enable)
        |-> ((pci_ad_o ^ held.addr) & low_mask) == 32'h0
            && ((pci_ad_o ^ held.xlat_offset) & ~low_mask) == 32'h0)
        else $error("translated address wrong");
    chk_io_codes: assert property ( // see [RL7]
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        ($fell(pci_frame_n_o) && held.op == PMRA_OP_IO_WR)
        |-> pci_cmd_byte_en_n_o == 4'h3)
        else $error("io write code wrong");

endmodule // pmra_master

// >>> test/pmra_arb_model.sv
`timescale 1ns/1ps

// Outside arbiter and addressed target, as seen from this master
module pmra_arb_model (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic slow_i,
    input wire logic pci_req_n_i,
    input wire logic pci_frame_n_i,
    output logic pci_grant_n_o,
    output logic addr_done_o
);
    logic [2:0] wait_cnt;
    logic [1:0] phase_cnt;

    // Grant comes promptly or after three cycles; the pulled-up grant
    // line returns high as soon as the request is withdrawn
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            wait_cnt <= 3'h0;
            phase_cnt <= 2'h0;
            pci_grant_n_o <= 1'b1;
            addr_done_o <= 1'b0;
        end else begin
            if (!pci_req_n_i) begin
                wait_cnt <= wait_cnt + 3'h1;
                pci_grant_n_o <= !(wait_cnt >= (slow_i ? 3'h3 : 3'h0));
            end else begin
                wait_cnt <= 3'h0;
                pci_grant_n_o <= 1'b1;
            end
            // Ends the transaction a fixed time after frame falls
            addr_done_o <= !pci_frame_n_i && phase_cnt == 2'h2;
            phase_cnt <= pci_frame_n_i ? 2'h0 : phase_cnt + 2'h1;
        end
    end
endmodule // pmra_arb_model

// >>> test/tb_pci_master_request_address.sv
`timescale 1ns/1ps

module tb_pci_master_request_address;
    import pmra_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic req_valid = 1'b0;
    logic bme = 1'b1;
    logic arb_int = 1'b0;
    logic other_req = 1'b0;
    logic busy = 1'b0;
    logic slow = 1'b0;
    pmra_req_type req = '0;
    logic grant_n, done, ready, req_n, ireq, igrant, frame_n, frame_oe;
    logic cmd_oe, ad_oe, active, wie;
    logic [3:0] cmd;
    logic [31:0] ad;
    int n_mismatch = 0;
    int num_checks = 0;
    int cycles = 0;
    pmra_op_type ops[9] = '{PMRA_OP_IO_RD, PMRA_OP_IO_WR, PMRA_OP_MEM_RD,
        PMRA_OP_MEM_WR, PMRA_OP_MEM_RDM, PMRA_OP_MEM_RDL, PMRA_OP_IACK,
        PMRA_OP_CFG_RD, PMRA_OP_CFG_WR};
    logic [3:0] codes[9] = '{4'h2, 4'h3, 4'h6, 4'h7, 4'hC, 4'hE, 4'h0,
        4'hA, 4'hB};

    always #5 clk_sys_i = ~clk_sys_i;

    pmra_master u_dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
        .req_valid_i(req_valid), .req_i(req), .bus_master_enable_i(bme),
        .arb_internal_i(arb_int), .other_req_i(other_req),
        .target_busy_i(busy), .pci_grant_n_i(grant_n), .addr_done_i(done),
        .req_ready_o(ready), .pci_req_n_o(req_n), .int_req_o(ireq),
        .int_grant_o(igrant), .pci_frame_n_o(frame_n),
        .pci_frame_oe_o(frame_oe), .pci_cmd_byte_en_n_o(cmd),
        .pci_cmd_oe_o(cmd_oe), .pci_ad_o(ad), .pci_ad_oe_o(ad_oe),
        .master_active_o(active), .write_invalidate_enable_o(wie));

    pmra_arb_model u_arb (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
        .slow_i(slow), .pci_req_n_i(req_n), .pci_frame_n_i(frame_n),
        .pci_grant_n_o(grant_n), .addr_done_o(done));

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic complete_run;
        $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Inputs always move 1 ns after the rising edge
    task automatic step;
        @(posedge clk_sys_i);
        #1;
    endtask

    // Bounded waits so a stuck handshake shows as a mismatch, not a hang
    task automatic xfer(input pmra_op_type op, input logic [31:0] addr,
        input logic te, input logic [4:0] bs, input logic [31:0] off,
        input logic [3:0] code, input logic [31:0] exp_ad);
        int k;
        for (k = 0; ready !== 1'b1 && k < 20; k++) step();
        req = '{addr, op, PMRA_SRC_PROC, te, bs, off};
        req_valid = 1'b1;
        step();
        req_valid = 1'b0;
        check(active, 1);
        check({req_n, ireq}, arb_int ? 2'b11 : 2'b00);
        for (k = 0; frame_n !== 1'b0 && k < 20; k++) step();
        check({frame_oe, cmd_oe, ad_oe}, 3'b111);
        check(cmd, code);
        check(ad, exp_ad);
        for (k = 0; ready !== 1'b1 && k < 20; k++) step();
        check({frame_n, cmd}, 5'h1F);
    endtask

    // Every supported command, both arbiter modes, no translation
    task automatic t_cmds;
        for (int i = 0; i < 18; i++) begin
            slow = i[0];
            arb_int = (i >= 9);
            xfer(ops[i % 9], 32'h1000_0000 + i * 4, 1'b0, 5'h0C,
                32'hFFFF_F000, codes[i % 9],
                32'h1000_0000 + i * 4);
        end
        $display("test cmds done");
    endtask

    // Upper bits from the offset, bits inside the block from the source
    task automatic t_xlat;
        logic [4:0] sizes[3] = '{5'h00, 5'h0C, 5'h1F};
        // Worked by hand: all offset, 12 low source bits, 31 low bits
        logic [31:0] want_ad[3] = '{32'h5A5A_5A5A, 32'h5A5A_5DEF,
            32'h09AB_CDEF};
        for (int i = 0; i < 3; i++) begin
            xfer(PMRA_OP_MEM_WR, 32'h89AB_CDEF, 1'b1, sizes[i], 32'h5A5A_5A5A,
                4'h7, want_ad[i]);
        end
        $display("test xlat done");
    endtask

    // Parking on this master, and losing the park to another master
    task automatic t_park;
        arb_int = 1'b1;
        step();
        step();
        check(igrant, 1);
        other_req = 1'b1;
        step();
        step();
        check(igrant, 0);
        xfer(PMRA_OP_MEM_RDL, 32'h0000_0040, 1'b0, 5'h0, 32'h0, 4'hE,
            32'h0000_0040);
        other_req = 1'b0;
        $display("test park done");
    endtask

    // No request while mastering is off or the target side is busy
    task automatic t_refuse;
        req_valid = 1'b1;
        for (int i = 0; i < 2; i++) begin
            bme = (i == 1);
            busy = (i == 1);
            repeat (4) step();
            check({active, req_n, ireq, frame_n}, 4'b0101);
        end
        req_valid = 1'b0;
        bme = 1'b1;
        busy = 1'b0;
        check(wie, 0);
        // Losing bus master enable while waiting for a grant drops to idle
        arb_int = 1'b0;
        slow = 1'b1;
        req = '{32'h0000_0080, PMRA_OP_MEM_RD, PMRA_SRC_ALT, 1'b0, 5'h0, 32'h0};
        req_valid = 1'b1;
        step();
        req_valid = 1'b0;
        check({active, req_n}, 2'b10);
        bme = 1'b0;
        step();
        step();
        check({active, req_n, frame_n}, 3'b011);
        bme = 1'b1;
        $display("test refuse done");
    endtask

    // Cut a hang short well past the expected run length
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            complete_run();
        end
    end

    initial begin
        repeat (8) @(posedge clk_sys_i);
        #1;
        check({req_n, frame_n, cmd, ad, frame_oe, cmd_oe, ad_oe, active,
            ready, ireq, igrant}, 45'h1F80_0000_0000);
        check(wie, 0);
        rst_b_i = 1'b1;
        t_cmds();
        t_xlat();
        t_park();
        t_refuse();
        complete_run();
    end
endmodule // tb_pci_master_request_address
